// [rtl/uart_interrupt_flags.sv]
// Interrupt flag logic for a low-energy asynchronous serial port.
// Assumes event pulses and buffer levels from the datapath are synchronous
// to MCLK_I; registers are reached over a plain strobe port.
`default_nettype none

// Operation
// - Signal frame match sets bit 10
// - Start frame match sets bit 9
// - Address frame detected sets bit 8
// - Framing error sets bit 7 unless blocking
// - Parity error sets bit 6 unless blocking
// - Write to full transmit buffer: bit 5, discard
// - Read of empty receive buffer sets bit 4
// - Frame into full shifter: bit 3, overwrite
// - Receive data available sets bit 2
// - Transmit space sets bit 1, resets one
// - Transmit idle after sending sets bit 0
// - Set register writes ones into sticky flags
// - Clear register writes ones clear sticky flags
// - Enable bit per flag, reset zero
module uart_interrupt_flags (
  // Clock and reset
  input  wire logic                              MCLK_I,
  input  wire logic                              SYS_RST_I,
  // Register port
  input  wire logic [uart_flags_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [uart_flags_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                              WR_I,
  input  wire logic                              RD_I,
  output logic      [uart_flags_pkg::DATA_W-1:0] RDATA_O,
  // Receive side events
  input  wire logic                              SIGNAL_FRAME_I,
  input  wire logic                              BEGIN_FRAME_I,
  input  wire logic                              ADDR_FRAME_I,
  input  wire logic                              FRAMING_ERR_I,
  input  wire logic                              PARITY_ERR_I,
  input  wire logic                              FRAME_IN_I,
  input  wire logic                              RX_SHIFT_FULL_I,
  input  wire logic                              RX_READ_I,
  input  wire logic                              RX_AVAIL_I,
  // Transmit side events
  input  wire logic                              TX_WRITE_I,
  input  wire logic                              TX_FULL_I,
  input  wire logic                              TX_SPACE_I,
  input  wire logic                              TX_BUF_EMPTY_I,
  input  wire logic                              TX_SHIFT_EMPTY_I,
  // Datapath handshakes
  output logic                                   TX_ACCEPT_O,
  output logic                                   RX_LOAD_O,
  output logic                                   RX_TAKE_O,
  // Status and interrupt
  output logic      [uart_flags_pkg::NUM_FLAGS-1:0] FLAGS_O,
  output logic                                   RX_BLOCKING_O,
  output logic                                   IRQ_O
);

  localparam int unsigned NF = uart_flags_pkg::NUM_FLAGS;

  // Bundled request and event views
  uart_flags_pkg::bus_req_t   req;        // Current port request
  uart_flags_pkg::rx_events_t rx_ev;      // Receive pulses
  // Flag, enable and control state
  logic [NF-1:0]  flag_reg;               // Interrupt flags
  logic [NF-1:0]  flag_next;
  logic [NF-1:0]  en_reg;                 // Interrupt enables
  logic [NF-1:0]  en_next;
  logic           blocking_reg;           // Receive blocking control
  logic           blocking_next;
  logic           idle_reg;               // Transmit idle seen last cycle
  logic [uart_flags_pkg::DATA_W-1:0] rdata_reg;  // Read data, one cycle late
  logic [uart_flags_pkg::DATA_W-1:0] rdata_next;
  // Decode and event wires
  wire            hit_ctrl;
  wire            hit_flags;
  wire            hit_set;
  wire            hit_clr;
  wire            hit_en;
  wire            tx_idle;                // Buffer and shifter both empty
  wire [NF-1:0]   set_vec;                // Software set, one cycle
  wire [NF-1:0]   clr_vec;                // Software clear, one cycle
  wire [NF-1:0]   hw_set;                 // Hardware set pulses
  wire [NF-1:0]   hw_level;               // Levels for non-sticky flags
  wire [uart_flags_pkg::DATA_W-1:0] rd_mux;

  // Bundle the ports
  assign req   = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
  assign rx_ev = '{signal_frame: SIGNAL_FRAME_I, begin_frame: BEGIN_FRAME_I,
                   addr_frame: ADDR_FRAME_I, framing_err: FRAMING_ERR_I,
                   parity_err: PARITY_ERR_I, frame_in: FRAME_IN_I};

  // Address decode
  assign hit_ctrl  = (req.addr == uart_flags_pkg::CTRL_OFS);
  assign hit_flags = (req.addr == uart_flags_pkg::FLAGS_OFS);
  assign hit_set   = (req.addr == uart_flags_pkg::SET_OFS);
  assign hit_clr   = (req.addr == uart_flags_pkg::CLR_OFS);
  assign hit_en    = (req.addr == uart_flags_pkg::EN_OFS);

  // Level flag bits are masked so a stray one cannot touch the level flags
  assign set_vec = (req.wr && hit_set) ? (req.wdata[NF-1:0] & uart_flags_pkg::STICKY_MASK)
                                       : '0;
  assign clr_vec = (req.wr && hit_clr) ? (req.wdata[NF-1:0] & uart_flags_pkg::STICKY_MASK)
                                       : '0;

  // Transmit idle, edge-detected so the flag fires once per drain
  assign tx_idle = TX_BUF_EMPTY_I & TX_SHIFT_EMPTY_I;

  // Hardware set sources per flag
  assign hw_set[uart_flags_pkg::SIGNAL_FRAME_BIT] = rx_ev.signal_frame;
  assign hw_set[uart_flags_pkg::BEGIN_FRAME_BIT]  = rx_ev.begin_frame;
  assign hw_set[uart_flags_pkg::ADDR_FRAME_BIT]   = rx_ev.addr_frame;
  assign hw_set[uart_flags_pkg::FRAMING_ERR_BIT]  = rx_ev.framing_err & ~blocking_reg;
  assign hw_set[uart_flags_pkg::PARITY_ERR_BIT]   = rx_ev.parity_err & ~blocking_reg;
  assign hw_set[uart_flags_pkg::TX_OVERFLOW_BIT]  = TX_WRITE_I & TX_FULL_I;
  assign hw_set[uart_flags_pkg::RX_UNDERFLOW_BIT] = RX_READ_I & ~RX_AVAIL_I;
  assign hw_set[uart_flags_pkg::RX_OVERFLOW_BIT]  = rx_ev.frame_in & RX_SHIFT_FULL_I;
  assign hw_set[uart_flags_pkg::RX_VALID_BIT]     = 1'b0;
  assign hw_set[uart_flags_pkg::TX_SPACE_BIT]     = 1'b0;
  assign hw_set[uart_flags_pkg::TX_DONE_BIT]      = tx_idle & ~idle_reg;

  // Level sources; only the two buffer flags use them
  assign hw_level = {NF{1'b0}}
                  | (NF'(RX_AVAIL_I) << uart_flags_pkg::RX_VALID_BIT)
                  | (NF'(TX_SPACE_I) << uart_flags_pkg::TX_SPACE_BIT);

  // Per-flag next value: sticky flags hold, set beats clear in one cycle
  for (genvar i = 0; i < NF; i++) begin : g_flag
    if (uart_flags_pkg::STICKY_MASK[i]) begin : g_sticky
      assign flag_next[i] = (flag_reg[i] & ~clr_vec[i]) | set_vec[i] | hw_set[i];
    end else begin : g_level
      // Buffer flags mirror their level and ignore software
      assign flag_next[i] = hw_level[i];
    end
  end

  // Enable and control writes
  assign en_next       = (req.wr && hit_en) ? req.wdata[NF-1:0] : en_reg;
  assign blocking_next = (req.wr && hit_ctrl) ? req.wdata[uart_flags_pkg::RX_BLOCKING_BIT]
                                              : blocking_reg;

  // Read mux; set and clear registers read as zero, unmapped as zero
  assign rd_mux = hit_flags ? uart_flags_pkg::DATA_W'(flag_reg)
                : hit_en    ? uart_flags_pkg::DATA_W'(en_reg)
                : hit_ctrl  ? uart_flags_pkg::DATA_W'(blocking_reg)
                : '0;
  // Data stands only in the cycle after the read strobe
  assign rdata_next = req.rd ? rd_mux : '0;

  // Flag register, transmit space comes out of reset set
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      flag_reg <= uart_flags_pkg::FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Enables, control, idle history
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      en_reg       <= uart_flags_pkg::EN_RESET;
      blocking_reg <= uart_flags_pkg::CTRL_RESET;
      idle_reg     <= 1'b1;
    end else begin
      en_reg       <= en_next;
      blocking_reg <= blocking_next;
      idle_reg     <= tx_idle;
    end
  end

  // Read data register
  always_ff @(posedge MCLK_I) begin
    if (SYS_RST_I) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Datapath handshakes: full buffer refuses, shifter always reloads
  assign TX_ACCEPT_O = TX_WRITE_I & ~TX_FULL_I;
  assign RX_LOAD_O   = rx_ev.frame_in;
  // An empty receive buffer gives nothing on read
  assign RX_TAKE_O   = RX_READ_I & RX_AVAIL_I;

  // Outputs
  assign RDATA_O       = rdata_reg;
  assign FLAGS_O       = flag_reg;
  assign RX_BLOCKING_O = blocking_reg;
  assign IRQ_O         = |(flag_reg & en_reg);

endmodule

`default_nettype wire

// [pkg/uart_flags_pkg.sv]
// Constants and carrier types for the serial port interrupt flag block.
// Assumes a 32-bit register port with byte addresses and one clock domain.
`default_nettype none

package uart_flags_pkg;

  // Register port widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_FLAGS = 11;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] FLAGS_OFS = 8'h2C;
  localparam logic [ADDR_W-1:0] SET_OFS   = 8'h30;
  localparam logic [ADDR_W-1:0] CLR_OFS   = 8'h34;
  localparam logic [ADDR_W-1:0] EN_OFS    = 8'h38;

  // Flag bit positions
  localparam int unsigned SIGNAL_FRAME_BIT = 10;
  localparam int unsigned BEGIN_FRAME_BIT  = 9;
  localparam int unsigned ADDR_FRAME_BIT   = 8;
  localparam int unsigned FRAMING_ERR_BIT  = 7;
  localparam int unsigned PARITY_ERR_BIT   = 6;
  localparam int unsigned TX_OVERFLOW_BIT  = 5;
  localparam int unsigned RX_UNDERFLOW_BIT = 4;
  localparam int unsigned RX_OVERFLOW_BIT  = 3;
  localparam int unsigned RX_VALID_BIT     = 2;
  localparam int unsigned TX_SPACE_BIT     = 1;
  localparam int unsigned TX_DONE_BIT      = 0;

  // Control register field
  localparam int unsigned RX_BLOCKING_BIT = 0;

  // Reset values and bit classes
  localparam logic [NUM_FLAGS-1:0] FLAG_RESET  = 11'h002;
  localparam logic [NUM_FLAGS-1:0] EN_RESET    = 11'h000;
  localparam logic [NUM_FLAGS-1:0] STICKY_MASK = 11'h7F9;
  localparam logic                 CTRL_RESET  = 1'h0;

  // One register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } bus_req_t;

  // Receive side frame events, one-cycle pulses
  typedef struct packed {
    logic signal_frame;
    logic begin_frame;
    logic addr_frame;
    logic framing_err;
    logic parity_err;
    logic frame_in;
  } rx_events_t;

endpackage

`default_nettype wire

// [verification/uart_flags_assertions.sv]
// Checker for the serial port interrupt flag block.
// Assumes it sees only the top module's ports, one clock, sync reset.
`default_nettype none
module uart_flags_checker (
  // Clock, reset and register port
  input wire logic                              MCLK_I,
  input wire logic                              SYS_RST_I,
  input wire logic [uart_flags_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [uart_flags_pkg::DATA_W-1:0] WDATA_I,
  input wire logic                              WR_I,
  input wire logic                              RD_I,
  input wire logic [uart_flags_pkg::DATA_W-1:0] RDATA_O,
  // Events, handshakes and status
  input wire logic                              SIGNAL_FRAME_I,
  input wire logic                              FRAMING_ERR_I,
  input wire logic                              RX_READ_I,
  input wire logic                              RX_AVAIL_I,
  input wire logic                              TX_WRITE_I,
  input wire logic                              TX_FULL_I,
  input wire logic                              TX_ACCEPT_O,
  input wire logic [uart_flags_pkg::NUM_FLAGS-1:0] FLAGS_O,
  input wire logic                              RX_BLOCKING_O,
  input wire logic                              IRQ_O
);
  // Clear write aimed at the signal frame flag
  wire logic clr_sig = WR_I && ADDR_I == uart_flags_pkg::CLR_OFS && WDATA_I[10];
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Overflowing write is dropped, then flagged
  sequence transmit_overflow_flag_seen;
    !TX_ACCEPT_O ##1 FLAGS_O[5];
  endsequence
  chk_sig_frame: assert property (SIGNAL_FRAME_I |=> FLAGS_O[10])
    else $error("signal frame flag not raised");
  chk_framing_error_flag_open: assert property (FRAMING_ERR_I && !RX_BLOCKING_O |=> FLAGS_O[7])
    else $error("framing error flag not raised");
  chk_transmit_overflow_flag_drop: assert property (TX_WRITE_I && TX_FULL_I |-> transmit_overflow_flag_seen)
    else $error("full write not dropped and flagged");
  chk_receive_underflow_flag_set: assert property (RX_READ_I && !RX_AVAIL_I |=> FLAGS_O[4])
    else $error("underflow flag not raised");
  chk_valid_mirror: assert property (RX_AVAIL_I |=> FLAGS_O[2])
    else $error("data valid flag not following buffer");
  chk_clear_write: assert property (clr_sig && !SIGNAL_FRAME_I |=> !FLAGS_O[10])
    else $error("clear write left flag set");
  chk_flag_sticky: assert property (FLAGS_O[10] && !clr_sig |=> FLAGS_O[10])
    else $error("sticky flag dropped");
  chk_irq_enable: assert property (WR_I && ADDR_I == uart_flags_pkg::EN_OFS
    |=> IRQ_O == |(FLAGS_O & 11'($past(WDATA_I))))
    else $error("interrupt does not match enabled flags");
  chk_read_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind uart_interrupt_flags uart_flags_checker chk_i (.*);
`default_nettype wire

// [verification/uart_interrupt_flags_tb_top.sv]
// Self-checking bench for the serial port interrupt flag block.
// Assumes reads answer one cycle late and flags follow events by one cycle.
`default_nettype none
module uart_interrupt_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, wr, rd;       // Clock, reset, strobes
  logic        rd_d = 1'b0;           // Read seen at last edge
  logic [7:0]  addr, ev;              // Address; event pulses, bit i -> flag i+3
  logic [31:0] wdata, rdata, lfsr;    // Bus data, random state
  logic        avail, shfull, txfull, txspace, bufemp, shemp, irq;
  logic        txacc, rxload, rxtake, blk;  // Handshakes and blocking state
  logic [10:0] flags;                 // Flag register copy
  logic [31:0] exp_q[$];              // Expected read data, oldest first
  int          n_fail, check_count, cyc;
  uart_interrupt_flags dut (.MCLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .SIGNAL_FRAME_I(ev[7]), .BEGIN_FRAME_I(ev[6]), .ADDR_FRAME_I(ev[5]),
    .FRAMING_ERR_I(ev[4]), .PARITY_ERR_I(ev[3]), .TX_WRITE_I(ev[2]),
    .RX_READ_I(ev[1]), .FRAME_IN_I(ev[0]), .RX_SHIFT_FULL_I(shfull),
    .RX_AVAIL_I(avail), .TX_FULL_I(txfull), .TX_SPACE_I(txspace),
    .TX_BUF_EMPTY_I(bufemp), .TX_SHIFT_EMPTY_I(shemp), .TX_ACCEPT_O(txacc),
    .RX_LOAD_O(rxload), .RX_TAKE_O(rxtake), .FLAGS_O(flags), .RX_BLOCKING_O(blk),
    .IRQ_O(irq));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random source, seeded once
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp_irq(input logic exp);
    #1;
    check_count++;
    if (irq !== exp) begin
      n_fail++;
      $display("unexpected at %0t: interrupt %b, wanted %b", $time, irq, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read; the expectation is queued for the watcher
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  // Watcher: read data stands only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      cmp_data(rdata, exp_q.pop_front());
    end
  end
  // Handshakes: full buffer refuses, empty buffer gives nothing, shifter reloads
  always @(negedge clk) begin
    if (!rst && (ev[2] || ev[1] || ev[0])) begin
      cmp_data({29'h0, txacc, rxtake, rxload},
               {29'h0, ev[2] & ~txfull, ev[1] & avail, ev[0]});
    end
  end
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    {wr, rd, ev, avail, addr, wdata, cyc, n_fail, check_count} = '0;
    {rst, shfull, txfull, txspace, bufemp, shemp} = 6'h3F;
    lfsr = 32'h0000002C;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h002);
    rd_reg(uart_flags_pkg::EN_OFS, 32'h000);
    rd_reg(8'h3C, 32'h000);
    // Every sticky event but transmit done, with its causing condition
    for (int i = 0; i < 8; i++) begin
      pulse(8'(1 << i));
      repeat (3) @(posedge clk);
      rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h002 | (32'h8 << i));
      wr_reg(uart_flags_pkg::CLR_OFS, 32'h8 << i);
      rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h002);
    end
    // Errors ignored while receive blocking is on
    wr_reg(uart_flags_pkg::CTRL_OFS, 32'h1);
    #1 cmp_data({31'h0, blk}, 32'h1);
    pulse(8'h18);
    wr_reg(uart_flags_pkg::CTRL_OFS, 32'h0);
    rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h002);
    wr_reg(uart_flags_pkg::SET_OFS, 32'h7F9);
    rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h7FB);
    // Random enables against every flag but bit 2 set
    for (int k = 0; k < 4; k++) begin
      lfsr = next_rand(lfsr);
      wr_reg(uart_flags_pkg::EN_OFS, lfsr & 32'h7FF);
      rd_reg(uart_flags_pkg::EN_OFS, lfsr & 32'h7FF);
      cmp_irq(|(lfsr[10:0] & 11'h7FB));
    end
    wr_reg(uart_flags_pkg::CLR_OFS, 32'h7F9);
    cmp_irq(lfsr[1]);
    // Level flags and transmit completion; non-faulting accesses
    @(posedge clk);
    {avail, txspace, bufemp, txfull} <= 4'h8;
    pulse(8'h06);
    bufemp <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h005);
    txspace <= 1'b1;
    repeat (2) @(posedge clk);
    rd_reg(uart_flags_pkg::FLAGS_OFS, 32'h007);
    repeat (3) @(posedge clk);
    #1 cmp_data({21'h0, flags}, 32'h007);
    print_verdict();
  end
endmodule
`default_nettype wire
